// [src/dio_pkg.sv]
package dio_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 32'h0262_5A00; // 40 MHz core clock
   localparam int unsigned HZ_PER_KHZ = 32'h0000_03E8;
   localparam int unsigned TICK_MS = 32'h0000_0001; // time base period, ms
   // cycles per time-base tick, derived from the clock rate
   localparam int unsigned TICK_CYCLES = CLK_HZ / HZ_PER_KHZ * TICK_MS;

   // ****************************************
   // setting limits and defaults (ms or units)
   // ****************************************
   localparam logic [15:0] ACT_MAX_MS = 16'hEA60; // 60000 ms
   localparam logic [13:0] HOLD_MAX_MS = 14'h270F; // 9999 ms
   localparam logic [7:0] CAB_MAX_MS = 8'hC8; // 200 ms
   localparam logic [7:0] CAB_DEF_MS = 8'h05; // 5 ms
   localparam logic [9:0] FLT_MAX_MS = 10'h3E8; // 1000 ms
   localparam logic signed [23:0] PULSE_HI_MAX = 24'sh0493E0; // 30.00 kHz
   localparam logic signed [23:0] PULSE_HI_DEF = 24'sh0493E0; // 30.00 kHz
   localparam logic signed [23:0] ENCODER_HI_DEF = 24'sh007530; // 3 kHz
   localparam logic [10:0] SCALE_FULL = 11'h3E8; // 100.0 %

   // ****************************************
   // register offsets (word index)
   // ****************************************
   localparam logic [5:0] A_DO_ACT = 6'h00; // +0..2 activation delay
   localparam logic [5:0] A_DO_CFG = 6'h04; // +0..2 hold, level, assign
   localparam logic [5:0] A_CAB = 6'h08; // +0..1 cabinet input setup
   localparam logic [5:0] A_LO = 6'h0C; // +0..2 0 % frequency
   localparam logic [5:0] A_HI = 6'h10; // +0..2 100 % frequency
   localparam logic [5:0] A_FLT = 6'h14; // +0..2 filter time
   localparam logic [5:0] A_REF = 6'h18; // encoder reference type
   localparam logic [5:0] A_STATUS = 6'h19; // pin and input levels
   localparam logic [5:0] A_SCALED = 6'h1C; // +0..2 filtered percent

   // field positions
   localparam int unsigned CFG_NEG_BIT = 16;
   localparam int unsigned CFG_ASG_LSB = 24;
   localparam int unsigned CAB_LO_LSB = 8;
   localparam int unsigned CAB_HI_LSB = 16;

   // output assignment codes that lock settings
   localparam logic [3:0] ASG_FAULT = 4'h1;
   localparam logic [3:0] ASG_MAINS = 4'h2;
   localparam logic [3:0] ASG_BRAKE = 4'h3;

   typedef enum logic {
      REF_QUAD = 1'b0,
      REF_PULSE = 1'b1
   } dio_ref_t;

   typedef struct packed {
      logic [3:0] asg;
      logic neg;
      logic [13:0] hold;
      logic [15:0] act;
   } dio_do_cfg_t;

   typedef struct packed {
      logic [7:0] hi_fn;
      logic [7:0] lo_fn;
      logic [7:0] dly;
   } dio_cab_cfg_t;

   typedef struct packed {
      logic signed [23:0] lo;
      logic signed [23:0] hi;
      logic [9:0] flt;
   } dio_scl_cfg_t;

   localparam dio_cab_cfg_t CAB_RST = '{hi_fn: 8'h00, lo_fn: 8'h00, dly: CAB_DEF_MS};
   localparam dio_scl_cfg_t PULSE_RST = '{lo: 24'sh000000, hi: PULSE_HI_DEF, flt: 10'h000};
   localparam dio_scl_cfg_t ENCODER_RST = '{lo: 24'sh000000, hi: ENCODER_HI_DEF, flt: 10'h000};

endpackage

// [src/dio_conditioner.sv]
`timescale 1ns/100ps

module dio_conditioner #(
   parameter int unsigned TICK_CYC = dio_pkg::TICK_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rst_b_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [2:0] out_cond_in,
   output logic base_digital_output_out,
   output logic ext_digital_output_a_out,
   output logic ext_digital_output_b_out,
   input wire logic cabinet_input_0_in,
   input wire logic cabinet_input_1_in,
   output logic [1:0] cabinet_cmd_out,
   output logic [7:0] cabinet_fn_0_out,
   output logic [7:0] cabinet_fn_1_out,
   input wire logic signed [23:0] pulse_input_a_freq_in,
   input wire logic signed [23:0] pulse_input_b_freq_in,
   input wire logic signed [23:0] quadrature_source_freq_in,
   input wire logic signed [23:0] pulse_train_source_freq_in,
   output logic [10:0] pulse_input_a_pct_out,
   output logic [10:0] pulse_input_b_pct_out,
   output logic [10:0] encoder_pct_out
);

   // ****************************************
   // declarations
   // ****************************************
   logic [15:0] tdiv_q; // time-base divider
   logic [15:0] tdiv_d;
   logic tick_q; // one-cycle pulse each ms
   logic tick_d;
   dio_pkg::dio_do_cfg_t do_q [3]; // output settings
   dio_pkg::dio_do_cfg_t do_d [3];
   dio_pkg::dio_cab_cfg_t cab_q [2]; // cabinet input settings
   dio_pkg::dio_cab_cfg_t cab_d [2];
   dio_pkg::dio_scl_cfg_t scl_q [3]; // frequency scaling settings
   dio_pkg::dio_scl_cfg_t scl_d [3];
   dio_pkg::dio_ref_t ref_q; // encoder reference type
   dio_pkg::dio_ref_t ref_d;
   logic [31:0] rdata_q; // read data, one cycle late
   logic [31:0] rdata_d;
   logic [4:0] ch_in; // raw level per delay channel
   logic [4:0] st_w; // delayed level per channel
   logic [15:0] dly_up [5]; // delay toward high
   logic [15:0] dly_dn [5]; // delay toward low
   logic [15:0] cnt_w [5]; // elapsed ticks per channel
   logic [2:0] pin_q; // output pins
   logic [2:0] pin_d;
   logic [7:0] fn_q [2]; // active cabinet function
   logic [7:0] fn_d [2];
   logic signed [23:0] fx [3]; // measured frequency
   logic [10:0] raw_w [3]; // unfiltered percent
   logic [10:0] pct_w [3]; // filtered percent

   // fault and mains may not be delayed on the way in
   function automatic logic act_lock(input logic [3:0] a);
      return (a == dio_pkg::ASG_FAULT) || (a == dio_pkg::ASG_MAINS);
   endfunction

   // brake joins them for hold delay and level
   function automatic logic full_lock(input logic [3:0] a);
      return act_lock(a) || (a == dio_pkg::ASG_BRAKE);
   endfunction

   // ****************************************
   // millisecond time base
   // ****************************************
   // divider runs free from reset; tick is one cycle wide
   always_comb begin
      tdiv_d = tdiv_q + 16'h0001;
      tick_d = 1'b0;
      if (tdiv_q >= 16'(TICK_CYC - 1)) begin
         tdiv_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         tdiv_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         tdiv_q <= tdiv_d;
         tick_q <= tick_d;
      end
   end

   // ****************************************
   // register writes
   // ****************************************
   // out-of-range values are refused and the old value kept
   always_comb begin
      logic [3:0] a;
      a = reg_wdata_in[dio_pkg::CFG_ASG_LSB +: 4];
      do_d = do_q;
      cab_d = cab_q;
      scl_d = scl_q;
      ref_d = ref_q;
      if (reg_wr_in) begin
         for (int k = 0; k < 3; k++) begin
            // activation delay, ignored while locked
            if (reg_addr_in == dio_pkg::A_DO_ACT + 6'(k)) begin
               if (!act_lock(do_q[k].asg) && reg_wdata_in[15:0] <= dio_pkg::ACT_MAX_MS) begin
                  do_d[k].act = reg_wdata_in[15:0];
               end
            end
            // assignment, holding delay, active level
            if (reg_addr_in == dio_pkg::A_DO_CFG + 6'(k)) begin
               do_d[k].asg = a;
               if (act_lock(a)) begin
                  do_d[k].act = 16'h0000;
               end
               if (full_lock(a)) begin
                  do_d[k].hold = 14'h0000;
                  do_d[k].neg = 1'b0;
               end else begin
                  do_d[k].neg = reg_wdata_in[dio_pkg::CFG_NEG_BIT];
                  if (reg_wdata_in[13:0] <= dio_pkg::HOLD_MAX_MS) begin
                     do_d[k].hold = reg_wdata_in[13:0];
                  end
               end
            end
            // scaling endpoints and filter time
            if (reg_addr_in == dio_pkg::A_LO + 6'(k)) begin
               scl_d[k].lo = reg_wdata_in[23:0];
            end
            if (reg_addr_in == dio_pkg::A_HI + 6'(k)) begin
               // pulse inputs stop at their top frequency
               if (k == 2 || $signed(reg_wdata_in[23:0]) <= dio_pkg::PULSE_HI_MAX) begin
                  scl_d[k].hi = reg_wdata_in[23:0];
               end
            end
            if (reg_addr_in == dio_pkg::A_FLT + 6'(k)) begin
               if (reg_wdata_in[9:0] <= dio_pkg::FLT_MAX_MS) begin
                  scl_d[k].flt = reg_wdata_in[9:0];
               end
            end
         end
         // cabinet input delay and both function codes
         for (int j = 0; j < 2; j++) begin
            if (reg_addr_in == dio_pkg::A_CAB + 6'(j)) begin
               cab_d[j].lo_fn = reg_wdata_in[dio_pkg::CAB_LO_LSB +: 8];
               cab_d[j].hi_fn = reg_wdata_in[dio_pkg::CAB_HI_LSB +: 8];
               if (reg_wdata_in[7:0] <= dio_pkg::CAB_MAX_MS) begin
                  cab_d[j].dly = reg_wdata_in[7:0];
               end
            end
         end
         if (reg_addr_in == dio_pkg::A_REF) begin
            ref_d = dio_pkg::dio_ref_t'(reg_wdata_in[0]);
         end
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   // unmapped offsets and idle cycles return zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (reg_rd_in) begin
         for (int k = 0; k < 3; k++) begin
            if (reg_addr_in == dio_pkg::A_DO_ACT + 6'(k)) begin
               rdata_d = {16'h0000, do_q[k].act};
            end
            if (reg_addr_in == dio_pkg::A_DO_CFG + 6'(k)) begin
               rdata_d = {4'h0, do_q[k].asg, 7'h00, do_q[k].neg, 2'h0, do_q[k].hold};
            end
            if (reg_addr_in == dio_pkg::A_LO + 6'(k)) begin
               rdata_d = {{8{scl_q[k].lo[23]}}, scl_q[k].lo};
            end
            if (reg_addr_in == dio_pkg::A_HI + 6'(k)) begin
               rdata_d = {{8{scl_q[k].hi[23]}}, scl_q[k].hi};
            end
            if (reg_addr_in == dio_pkg::A_FLT + 6'(k)) begin
               rdata_d = {22'h000000, scl_q[k].flt};
            end
            if (reg_addr_in == dio_pkg::A_SCALED + 6'(k)) begin
               rdata_d = {21'h000000, pct_w[k]};
            end
         end
         for (int j = 0; j < 2; j++) begin
            if (reg_addr_in == dio_pkg::A_CAB + 6'(j)) begin
               rdata_d = {8'h00, cab_q[j].hi_fn, cab_q[j].lo_fn, cab_q[j].dly};
            end
         end
         if (reg_addr_in == dio_pkg::A_REF) begin
            rdata_d = {31'h0000_0000, ref_q};
         end
         if (reg_addr_in == dio_pkg::A_STATUS) begin
            rdata_d = {27'h000_0000, st_w[4:3], pin_q};
         end
      end
   end

   // settings and read data register
   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         do_q <= '{default: '0};
         cab_q <= '{default: dio_pkg::CAB_RST};
         scl_q <= '{dio_pkg::PULSE_RST, dio_pkg::PULSE_RST, dio_pkg::ENCODER_RST};
         ref_q <= dio_pkg::REF_QUAD;
         rdata_q <= 32'h0000_0000;
      end else begin
         do_q <= do_d;
         cab_q <= cab_d;
         scl_q <= scl_d;
         ref_q <= ref_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // delay channels
   // ****************************************
   // channels 0..2 are outputs, 3..4 are cabinet inputs
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         ch_in[k] = out_cond_in[k];
         dly_up[k] = do_q[k].act;
         dly_dn[k] = {2'h0, do_q[k].hold};
      end
      ch_in[3] = cabinet_input_0_in;
      ch_in[4] = cabinet_input_1_in;
      for (int j = 0; j < 2; j++) begin
         dly_up[3 + j] = {8'h00, cab_q[j].dly};
         dly_dn[3 + j] = {8'h00, cab_q[j].dly};
      end
   end

   // one engine per channel; a tick arriving mid-ms makes the
   // first counted ms short by up to one tick period
   for (genvar c = 0; c < 5; c++) begin : g_dly
      logic st_r;
      logic st_n;
      logic [15:0] cnt_r;
      logic [15:0] cnt_n;
      logic [15:0] lim;

      always_comb begin
         lim = ch_in[c] ? dly_up[c] : dly_dn[c];
         st_n = st_r;
         cnt_n = 16'h0000;
         if (ch_in[c] != st_r) begin
            if (cnt_r >= lim) begin
               st_n = ch_in[c];
            end else begin
               cnt_n = cnt_r + {15'h0000, tick_q};
            end
         end
      end

      always_ff @(posedge core_clk_in) begin
         if (!rst_b_in) begin
            st_r <= 1'b0;
            cnt_r <= 16'h0000;
         end else begin
            st_r <= st_n;
            cnt_r <= cnt_n;
         end
      end

      assign st_w[c] = st_r;
      assign cnt_w[c] = cnt_r;
   end

   // ****************************************
   // pins and cabinet function codes
   // ****************************************
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         pin_d[k] = st_w[k] ^ do_q[k].neg;
      end
      for (int j = 0; j < 2; j++) begin
         fn_d[j] = st_w[3 + j] ? cab_q[j].hi_fn : cab_q[j].lo_fn;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_b_in) begin
         pin_q <= 3'h0;
         fn_q <= '{default: 8'h00};
      end else begin
         pin_q <= pin_d;
         fn_q <= fn_d;
      end
   end

   // ****************************************
   // frequency scaling and filter
   // ****************************************
   assign fx[0] = pulse_input_a_freq_in;
   assign fx[1] = pulse_input_b_freq_in;
   assign fx[2] = (ref_q == dio_pkg::REF_QUAD) ? quadrature_source_freq_in :
                  pulse_train_source_freq_in;

   // combinational divide keeps the path simple at 40 MHz at the
   // cost of area; a serial divider would trade it for latency
   for (genvar s = 0; s < 3; s++) begin : g_scl
      logic signed [24:0] d;
      logic signed [24:0] span;
      logic signed [35:0] prod;
      logic signed [11:0] diff;
      logic signed [11:0] step;
      logic [10:0] y_q;
      logic [10:0] y_d;

      always_comb begin
         d = {fx[s][23], fx[s]} - {scl_q[s].lo[23], scl_q[s].lo};
         span = {scl_q[s].hi[23], scl_q[s].hi} - {scl_q[s].lo[23], scl_q[s].lo};
         prod = $signed({{11{d[24]}}, d}) * 36'sh0000003E8;
         if (d <= 25'sh0 || span <= 25'sh0) begin
            raw_w[s] = 11'h000;
         end else if (d >= span) begin
            raw_w[s] = dio_pkg::SCALE_FULL;
         end else begin
            raw_w[s] = 11'(prod / $signed({{11{span[24]}}, span}));
         end
      end

      // first-order step toward target once per ms
      always_comb begin
         diff = $signed({1'b0, raw_w[s]}) - $signed({1'b0, y_q});
         step = diff / $signed({1'b0, 11'(scl_q[s].flt) + 11'h001});
         y_d = y_q;
         if (scl_q[s].flt == 10'h000) begin
            y_d = raw_w[s];
         end else if (tick_q) begin
            y_d = 11'($signed({1'b0, y_q}) + step);
         end
      end

      always_ff @(posedge core_clk_in) begin
         if (!rst_b_in) begin
            y_q <= 11'h000;
         end else begin
            y_q <= y_d;
         end
      end

      assign pct_w[s] = y_q;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata_out = rdata_q;
   assign base_digital_output_out = pin_q[0];
   assign ext_digital_output_a_out = pin_q[1];
   assign ext_digital_output_b_out = pin_q[2];
   assign cabinet_cmd_out = st_w[4:3];
   assign cabinet_fn_0_out = fn_q[0];
   assign cabinet_fn_1_out = fn_q[1];
   assign pulse_input_a_pct_out = pct_w[0];
   assign pulse_input_b_pct_out = pct_w[1];
   assign encoder_pct_out = pct_w[2];

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   property p_act_wait;
      $rose(st_w[1]) |-> $past(cnt_w[1]) >= $past(dly_up[1]);
   endproperty
   a_act_wait: assert property (p_act_wait)
      else $error("output rose before activation delay");

   property p_hold_wait;
      $fell(st_w[1]) |-> $past(cnt_w[1]) >= $past(dly_dn[1]);
   endproperty
   a_hold_wait: assert property (p_hold_wait)
      else $error("output fell before holding delay");

   property p_cab_wait;
      $changed(st_w[3]) |-> $past(cnt_w[3]) >= {8'h00, $past(cab_q[0].dly)};
   endproperty
   a_cab_wait: assert property (p_cab_wait)
      else $error("cabinet input acted before its delay");

   property p_restart;
      (ch_in[2] == st_w[2]) |=> (cnt_w[2] == 16'h0000);
   endproperty
   a_restart: assert property (p_restart)
      else $error("delay count not restarted");

   property p_act_lock;
      act_lock(do_q[2].asg) |-> (do_q[2].act == 16'h0000);
   endproperty
   a_act_lock: assert property (p_act_lock)
      else $error("locked output has activation delay");

   property p_hold_lock;
      full_lock(do_q[2].asg) |-> (do_q[2].hold == 14'h0000);
   endproperty
   a_hold_lock: assert property (p_hold_lock)
      else $error("locked output has holding delay");

   property p_level_lock;
      full_lock(do_q[2].asg) |=> !ext_digital_output_b_out || $past(st_w[2]);
   endproperty
   a_level_lock: assert property (p_level_lock)
      else $error("locked output inverted");

   property p_level;
      ##1 ext_digital_output_a_out == ($past(st_w[1]) ^ $past(do_q[1].neg));
   endproperty
   a_level: assert property (p_level)
      else $error("output level wrong");

   property p_nofilt;
      (scl_q[0].flt == 10'h000) |=> (pct_w[0] == $past(raw_w[0]));
   endproperty
   a_nofilt: assert property (p_nofilt)
      else $error("unfiltered input lags");

   property p_clamp;
      (raw_w[2] <= dio_pkg::SCALE_FULL) && (pct_w[1] <= dio_pkg::SCALE_FULL);
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("scaled value above full scale");

   c_delayed_rise: cover property ($rose(st_w[1]) && do_q[1].act != 16'h0000);
   c_cab_change: cover property ($changed(st_w[4]));
   c_full_scale: cover property (pct_w[2] == dio_pkg::SCALE_FULL);
   c_pulse_ref: cover property (ref_q == dio_pkg::REF_PULSE && raw_w[2] != 11'h000);

endmodule

// [test/dio_field_model.sv]
`timescale 1ns/100ps
// ****
// field side: contacts and frequency sources
// ****
module dio_field_model (
   input wire logic core_clk_in,
   input wire logic [2:0] cond_set_in,
   input wire logic [1:0] cab_set_in,
   input wire logic [1:0] src_sel_in,
   input wire logic signed [23:0] freq_set_in,
   output logic [2:0] cond_out = 3'h0,
   output logic [1:0] cab_out = 2'h0,
   output logic signed [23:0] freq_a_out = 24'sh000000,
   output logic signed [23:0] freq_b_out = 24'sh000000,
   output logic signed [23:0] freq_quad_out = 24'sh000000,
   output logic signed [23:0] freq_train_out = 24'sh000000
);
   // contacts settle one clock after the bench moves them
   always @(posedge core_clk_in) begin
      cond_out <= cond_set_in;
      cab_out <= cab_set_in;
      // only the selected source is wired; an open source measures nothing
      freq_a_out <= (src_sel_in == 2'h0) ? freq_set_in : 24'sh000000;
      freq_b_out <= (src_sel_in == 2'h1) ? freq_set_in : 24'sh000000;
      freq_quad_out <= (src_sel_in == 2'h2) ? freq_set_in : 24'sh000000;
      freq_train_out <= (src_sel_in == 2'h3) ? freq_set_in : 24'sh000000;
   end
endmodule

// [test/dio_conditioner_tb.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module dio_conditioner_tb;
   // ****
   // signals
   // ****
   localparam int unsigned T = 4; // short tick keeps every delay brief
   logic core_clk, rst_b, wr, rd;
   logic [5:0] addr;
   logic [31:0] wdata, rdata;
   logic [2:0] cond, cond_m;
   logic [1:0] cab, cab_m, sel, cmd;
   logic signed [23:0] fset, fa, fb, fq, ft;
   logic [10:0] pa, pb, pe;
   logic [7:0] fn0, fn1;
   logic base_o, ext_a, ext_b;
   int errors, comparisons, cyc, i;
   dio_field_model field (.core_clk_in(core_clk), .cond_set_in(cond), .cab_set_in(cab),
      .src_sel_in(sel), .freq_set_in(fset), .cond_out(cond_m), .cab_out(cab_m),
      .freq_a_out(fa), .freq_b_out(fb), .freq_quad_out(fq), .freq_train_out(ft));
   dio_conditioner #(.TICK_CYC(T)) DUT (.core_clk_in(core_clk), .rst_b_in(rst_b),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .out_cond_in(cond_m), .base_digital_output_out(base_o),
      .ext_digital_output_a_out(ext_a), .ext_digital_output_b_out(ext_b),
      .cabinet_input_0_in(cab_m[0]), .cabinet_input_1_in(cab_m[1]),
      .cabinet_cmd_out(cmd), .cabinet_fn_0_out(fn0), .cabinet_fn_1_out(fn1),
      .pulse_input_a_freq_in(fa), .pulse_input_b_freq_in(fb),
      .quadrature_source_freq_in(fq), .pulse_train_source_freq_in(ft),
      .pulse_input_a_pct_out(pa), .pulse_input_b_pct_out(pb), .encoder_pct_out(pe));
   // ****
   // access tasks
   // ****
   // wait n edges, then look once the edge has settled
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      `CHK("register", e, rdata)
   endtask
   task automatic drive(input logic [2:0] c, input logic [1:0] k);
      @(posedge core_clk);
      cond <= c;
      cab <= k;
   endtask
   task automatic freq(input logic [1:0] s, input logic [23:0] f);
      @(posedge core_clk);
      sel <= s;
      fset <= f;
      step(4);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ****
   // clock and hang guard
   // ****
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         report_and_stop();
      end
   end
   // ****
   // test sequence
   // ****
   initial begin
      {rst_b, wr, rd, cond, cab, sel} = 10'h000;
      addr = 6'h00;
      wdata = 32'h0000_0000;
      fset = 24'sh000000;
      {errors, comparisons, cyc} = '0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      // defaults and an unmapped place
      rd_chk(dio_pkg::A_CAB, 32'h0000_0005);
      rd_chk(dio_pkg::A_HI, 32'h0004_93E0);
      rd_chk(dio_pkg::A_HI + 6'h02, 32'h0000_7530);
      rd_chk(dio_pkg::A_LO + 6'h02, 32'h0000_0000);
      rd_chk(dio_pkg::A_REF, 32'h0000_0000);
      rd_chk(6'h3F, 32'h0000_0000);
      // limits: one past is refused; only the activation delay is also tried at its boundary, which is kept
      wr_reg(dio_pkg::A_DO_ACT, 32'h0000_EA61);
      rd_chk(dio_pkg::A_DO_ACT, 32'h0000_0000);
      wr_reg(dio_pkg::A_DO_ACT, 32'h0000_EA60);
      rd_chk(dio_pkg::A_DO_ACT, 32'h0000_EA60);
      wr_reg(dio_pkg::A_DO_CFG, 32'h0000_2710);
      rd_chk(dio_pkg::A_DO_CFG, 32'h0000_0000);
      wr_reg(dio_pkg::A_CAB + 6'h01, 32'h0000_00C9);
      rd_chk(dio_pkg::A_CAB + 6'h01, 32'h0000_0005);
      wr_reg(dio_pkg::A_FLT, 32'h0000_03E9);
      rd_chk(dio_pkg::A_FLT, 32'h0000_0000);
      // locking assignments: fault, mains, brake
      // brake first, so the mains write after it must clear its delay
      for (i = 3; i > 0; i--) begin
         wr_reg(dio_pkg::A_DO_CFG + 6'h02, (32'(i) << 24) | 32'h0001_0005);
         rd_chk(dio_pkg::A_DO_CFG + 6'h02, 32'(i) << 24);
         wr_reg(dio_pkg::A_DO_ACT + 6'h02, 32'h0000_0007);
         rd_chk(dio_pkg::A_DO_ACT + 6'h02, (i == 3) ? 32'h0000_0007 : 32'h0000_0000);
      end
      wr_reg(dio_pkg::A_DO_CFG + 6'h02, 32'h0000_0000);
      // base output: 3 ticks on, 2 ticks off, short pulse dropped
      wr_reg(dio_pkg::A_DO_ACT, 32'h0000_0003);
      wr_reg(dio_pkg::A_DO_CFG, 32'h0000_0002);
      drive(3'h1, 2'h0);
      drive(3'h0, 2'h0);
      step(16);
      `CHK("base pin", 1'b0, base_o)
      drive(3'h1, 2'h0);
      step(10);
      `CHK("base pin", 1'b0, base_o)
      step(6);
      `CHK("base pin", 1'b1, base_o)
      drive(3'h0, 2'h0);
      step(6);
      `CHK("base pin", 1'b1, base_o)
      step(6);
      `CHK("base pin", 1'b0, base_o)
      // inverted level on ext a, ext b independent
      wr_reg(dio_pkg::A_DO_CFG + 6'h01, 32'h0001_0000);
      step(3);
      `CHK("ext a pin", 1'b1, ext_a)
      drive(3'h6, 2'h0);
      step(4);
      `CHK("ext a pin", 1'b0, ext_a)
      `CHK("ext b pin", 1'b1, ext_b)
      // cabinet: input 0 waits 5 ticks, input 1 none
      wr_reg(dio_pkg::A_CAB, 32'h00A5_3C05);
      wr_reg(dio_pkg::A_CAB + 6'h01, 32'h0077_0000);
      step(2);
      `CHK("cab fn", 8'h3C, fn0)
      drive(3'h0, 2'h3);
      step(3);
      `CHK("cab cmd", 2'h2, cmd)
      `CHK("cab fn 1", 8'h77, fn1)
      step(15);
      `CHK("cab cmd", 2'h2, cmd)
      step(6);
      `CHK("cab cmd", 2'h3, cmd)
      `CHK("cab fn", 8'hA5, fn0)
      rd_chk(dio_pkg::A_STATUS, 32'h0000_001A);
      // scaling of pulse inputs and encoder
      freq(2'h0, 24'h0249F0);
      `CHK("pct a", 11'h1F4, pa)
      freq(2'h0, 24'h0493E1);
      `CHK("pct a", 11'h3E8, pa)
      wr_reg(dio_pkg::A_LO + 6'h01, 32'h0001_86A0);
      freq(2'h1, 24'h0186A0);
      `CHK("pct b", 11'h000, pb)
      freq(2'h1, 24'h030D40);
      `CHK("pct b", 11'h1F4, pb)
      freq(2'h2, 24'h003A98);
      `CHK("pct encoder", 11'h1F4, pe)
      wr_reg(dio_pkg::A_REF, 32'h0000_0001);
      freq(2'h3, 24'h001770);
      `CHK("pct encoder", 11'h0C8, pe)
      wr_reg(dio_pkg::A_LO + 6'h02, 32'h00FF_8AD0);
      rd_chk(dio_pkg::A_LO + 6'h02, 32'hFFFF_8AD0);
      freq(2'h3, 24'h000000);
      `CHK("pct encoder", 11'h1F4, pe)
      rd_chk(dio_pkg::A_SCALED + 6'h02, 32'h0000_01F4);
      // filtered step climbs over several ticks
      wr_reg(dio_pkg::A_FLT, 32'h0000_0001);
      freq(2'h0, 24'h000000);
      freq(2'h0, 24'h0493E0);
      `CHK("pct a slow", 1'b1, pa < 11'h3E8)
      step(60);
      `CHK("pct a settled", 1'b1, pa >= 11'h3E7)
      report_and_stop();
   end
endmodule
